// ===== rtl/fsrep_top.sv
// status reporting of one flash bank: status byte on reads, burst wait output
// assumes decoded command strokes and core events, all synchronous to CLK_IN
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.

module fsrep_top #(
	parameter int unsigned PROT_ERASE_CYC = fsrep_pkg::PROT_ERASE_CYC,
	parameter int unsigned PROT_PROG_CYC  = fsrep_pkg::PROT_PROG_CYC,
	parameter int unsigned ERASE_TMO_CYC  = fsrep_pkg::ERASE_TMO_CYC
) (
	input  wire logic                      CLK_IN,
	input  wire logic                      RESETN_IN,
	input  wire fsrep_pkg::fsrep_cmd_in_t  CMD_IN,
	input  wire fsrep_pkg::fsrep_core_t    CORE_IN,
	input  wire fsrep_pkg::fsrep_read_t    READ_IN,
	input  wire fsrep_pkg::fsrep_burst_t   BURST_IN,
	input  wire fsrep_pkg::fsrep_axi_req_t AXI_REQ_IN,
	output fsrep_pkg::fsrep_axi_rsp_t      AXI_RSP_OUT,
	output logic [7:0]                     DQ_OUT,
	output logic                           WAIT_N_OUT,
	output logic                           BUSY_OUT
);

	typedef struct packed {
		fsrep_pkg::fsrep_state_t       st;
		logic                          erase_op;
		logic                          chip;
		logic                          susp_fail;
		logic                          halted;
		logic                          estart;
		logic                          cpl;
		logic                          tog1;
		logic                          tog2;
		logic [fsrep_pkg::CNT_W-1:0]   cnt;
		logic [1:0]                    wcnt;
		logic [7:0]                    dq;
		logic                          wait_n;
		logic                          busy;
	} fsrep_top_t;

	fsrep_top_t cur_ff;
	fsrep_top_t nxt_top;
	logic       wait2;
	logic       cmd_is;
	logic       rd_bank;
	logic       rst_cmd;
	logic       show_stat;
	logic [7:0] stat_byte;
	logic [31:0] stat_word;

	// ----------------------------------------
	// register slave
	// ----------------------------------------
	assign stat_word = {24'h00_0000, cur_ff.estart, cur_ff.halted, cur_ff.susp_fail, cur_ff.busy,
		cur_ff.st};

	fsrep_regs u_regs (
		.clk_in    (CLK_IN),
		.resetn_in (RESETN_IN),
		.req_in    (AXI_REQ_IN),
		.stat_in   (stat_word),
		.wait2_out (wait2),
		.rsp_out   (AXI_RSP_OUT)
	);

	// ----------------------------------------
	// sequencer and status byte
	// ----------------------------------------
	assign cmd_is  = CMD_IN.valid;
	assign rd_bank = READ_IN.valid && READ_IN.in_bank;
	assign rst_cmd = CMD_IN.valid && CMD_IN.data == fsrep_pkg::RESET_DATA;

	always_comb begin
		nxt_top = cur_ff;
		if (cur_ff.cnt != '0) begin
			nxt_top.cnt = cur_ff.cnt - 1'b1;
		end
		case (cur_ff.st)
			fsrep_pkg::ST_READ: begin
				nxt_top.estart    = 1'b0;
				nxt_top.halted    = 1'b0;
				nxt_top.susp_fail = 1'b0;
				nxt_top.chip      = 1'b0;
				if (cmd_is && CMD_IN.code == fsrep_pkg::CMD_PROG) begin
					nxt_top.erase_op = 1'b0;
					nxt_top.cpl      = !CMD_IN.bit7;
					if (CMD_IN.prot) begin
						nxt_top.st  = fsrep_pkg::ST_PROT;
						nxt_top.cnt = fsrep_pkg::CNT_W'(PROT_PROG_CYC);
					end else begin
						nxt_top.st = fsrep_pkg::ST_PROG;
					end
				end else if (cmd_is && (CMD_IN.code == fsrep_pkg::CMD_SECT_ERASE
					|| CMD_IN.code == fsrep_pkg::CMD_CHIP_ERASE)) begin
					nxt_top.erase_op = 1'b1;
					nxt_top.cpl      = 1'b0;
					if (CMD_IN.prot) begin
						nxt_top.st  = fsrep_pkg::ST_PROT;
						nxt_top.cnt = fsrep_pkg::CNT_W'(PROT_ERASE_CYC);
					end else if (CMD_IN.code == fsrep_pkg::CMD_CHIP_ERASE) begin
						nxt_top.st     = fsrep_pkg::ST_ERASE;
						nxt_top.chip   = 1'b1;
						nxt_top.estart = 1'b1;
					end else begin
						nxt_top.st  = fsrep_pkg::ST_ETMO;
						nxt_top.cnt = fsrep_pkg::CNT_W'(ERASE_TMO_CYC);
					end
				end
			end
			fsrep_pkg::ST_ETMO: begin
				if (cmd_is && CMD_IN.code == fsrep_pkg::CMD_SECT_ERASE) begin
					nxt_top.cnt = fsrep_pkg::CNT_W'(ERASE_TMO_CYC);
				end else if (cmd_is && CMD_IN.code == fsrep_pkg::CMD_SUSPEND) begin
					nxt_top.st     = fsrep_pkg::ST_SUSP;
					nxt_top.estart = 1'b1;
				end else if (cur_ff.cnt == '0) begin
					nxt_top.st     = fsrep_pkg::ST_ERASE;
					nxt_top.estart = 1'b1;
				end
			end
			fsrep_pkg::ST_ERASE: begin
				if (CORE_IN.pulse_limit) begin
					nxt_top.st = fsrep_pkg::ST_FAIL;
				end else if (CORE_IN.done) begin
					nxt_top.st = fsrep_pkg::ST_LAST;
				end else if (cmd_is && CMD_IN.code == fsrep_pkg::CMD_SUSPEND && !cur_ff.chip) begin
					nxt_top.st = fsrep_pkg::ST_SUSP;
				end
			end
			fsrep_pkg::ST_SUSP: begin
				if (cmd_is && CMD_IN.code == fsrep_pkg::CMD_RESUME) begin
					nxt_top.st  = fsrep_pkg::ST_ERASE;
					nxt_top.cpl = 1'b0;
				end else if (cmd_is && CMD_IN.code == fsrep_pkg::CMD_PROG) begin
					nxt_top.st  = fsrep_pkg::ST_SPROG;
					nxt_top.cpl = !CMD_IN.bit7;
				end
			end
			fsrep_pkg::ST_PROG, fsrep_pkg::ST_SPROG: begin
				if (CORE_IN.over_zero) begin
					nxt_top.halted = 1'b1;
				end
				if (CORE_IN.pulse_limit) begin
					nxt_top.st        = fsrep_pkg::ST_FAIL;
					nxt_top.susp_fail = cur_ff.st == fsrep_pkg::ST_SPROG;
				end else if (CORE_IN.done && !cur_ff.halted) begin
					nxt_top.st = (cur_ff.st == fsrep_pkg::ST_SPROG) ? fsrep_pkg::ST_SUSP
						: fsrep_pkg::ST_LAST;
				end
			end
			fsrep_pkg::ST_PROT: begin
				if (cur_ff.cnt == '0) begin
					nxt_top.st = fsrep_pkg::ST_READ;
				end
			end
			fsrep_pkg::ST_FAIL: begin
				if (rst_cmd) begin
					nxt_top.st     = cur_ff.susp_fail ? fsrep_pkg::ST_SUSP : fsrep_pkg::ST_READ;
					nxt_top.halted = 1'b0;
				end
			end
			fsrep_pkg::ST_LAST: begin
				if (rd_bank) begin
					nxt_top.st = fsrep_pkg::ST_READ;
				end
			end
			default: nxt_top.st = fsrep_pkg::ST_READ;
		endcase

		// toggle bit one advances on bank reads while busy outside suspend; bit two on selected-sector reads in erase time-out, erase or suspend
		if (rd_bank && cur_ff.st != fsrep_pkg::ST_READ && cur_ff.st != fsrep_pkg::ST_SUSP) begin
			nxt_top.tog1 = !cur_ff.tog1;
		end
		if (rd_bank && READ_IN.sel && (cur_ff.st == fsrep_pkg::ST_ETMO
			|| cur_ff.st == fsrep_pkg::ST_ERASE || cur_ff.st == fsrep_pkg::ST_SUSP)) begin
			nxt_top.tog2 = !cur_ff.tog2;
		end

		stat_byte = 8'h00;
		stat_byte[fsrep_pkg::BIT_POLL]  = (cur_ff.st == fsrep_pkg::ST_SUSP) ? 1'b1 : cur_ff.cpl;
		stat_byte[fsrep_pkg::BIT_TOG1]  = nxt_top.tog1;
		stat_byte[fsrep_pkg::BIT_TMO]   = cur_ff.st == fsrep_pkg::ST_FAIL;
		stat_byte[fsrep_pkg::BIT_TIMER] = cur_ff.estart;
		stat_byte[fsrep_pkg::BIT_TOG2]  = nxt_top.tog2;
		if (cur_ff.st == fsrep_pkg::ST_LAST) begin
			stat_byte[fsrep_pkg::BIT_POLL] = !cur_ff.cpl;
		end
		show_stat = cur_ff.st != fsrep_pkg::ST_READ
			&& !(cur_ff.st == fsrep_pkg::ST_SUSP && !READ_IN.sel);
		if (READ_IN.valid) begin
			nxt_top.dq = (READ_IN.in_bank && show_stat) ? stat_byte : READ_IN.array;
		end
		nxt_top.busy = nxt_top.st != fsrep_pkg::ST_READ;

		// burst wait: reload at initial access and at each 64-word boundary
		if (!BURST_IN.active) begin
			nxt_top.wcnt = 2'h0;
		end else if (BURST_IN.start || (BURST_IN.word && BURST_IN.addr == fsrep_pkg::BURST_BOUND)) begin
			nxt_top.wcnt = wait2 ? fsrep_pkg::WAIT_TWO_CYC : fsrep_pkg::WAIT_ONE_CYC;
		end else if (cur_ff.wcnt != 2'h0) begin
			nxt_top.wcnt = cur_ff.wcnt - 2'h1;
		end
		nxt_top.wait_n = !(BURST_IN.active && nxt_top.wcnt != 2'h0);
	end

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			cur_ff        <= '0;
			cur_ff.st     <= fsrep_pkg::ST_READ;
			cur_ff.wait_n <= 1'b1;
		end else begin
			cur_ff <= nxt_top;
		end
	end

	assign DQ_OUT     = cur_ff.dq;
	assign WAIT_N_OUT = cur_ff.wait_n;
	assign BUSY_OUT   = cur_ff.busy;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_prot_hold_end: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		cur_ff.st == fsrep_pkg::ST_PROT && cur_ff.cnt == '0 |=> cur_ff.st == fsrep_pkg::ST_READ)
		else $error("protected hold did not end in read mode");

	chk_toggle_on_read: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		rd_bank && cur_ff.st == fsrep_pkg::ST_PROG |=> DQ_OUT[fsrep_pkg::BIT_TOG1] != $past(cur_ff.tog1))
		else $error("toggle bit one did not invert on busy read");

	chk_suspend_toggle_still: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		cur_ff.st == fsrep_pkg::ST_SUSP ##1 cur_ff.st == fsrep_pkg::ST_SUSP |-> $stable(cur_ff.tog1))
		else $error("toggle bit one moved in erase suspend");

	chk_prog_tog2_still: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		cur_ff.st == fsrep_pkg::ST_PROG |=> $stable(cur_ff.tog2))
		else $error("toggle bit two moved while programming");

	chk_suspend_array: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		rd_bank && cur_ff.st == fsrep_pkg::ST_SUSP && !READ_IN.sel |=> DQ_OUT == $past(READ_IN.array))
		else $error("suspend read of unselected sector gave status");

	chk_fail_timeout_bit: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		cur_ff.st == fsrep_pkg::ST_PROG && CORE_IN.pulse_limit ##1 !rst_cmd ##1 rd_bank
		|=> DQ_OUT[fsrep_pkg::BIT_TMO])
		else $error("timeout bit not shown after pulse limit");

	chk_timer_bit_low: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		rd_bank && cur_ff.st == fsrep_pkg::ST_ETMO |=> !DQ_OUT[fsrep_pkg::BIT_TIMER])
		else $error("timer bit high during erase time-out");

	chk_last_read_ends: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		rd_bank && cur_ff.st == fsrep_pkg::ST_LAST |=> cur_ff.st == fsrep_pkg::ST_READ ##0
		DQ_OUT[fsrep_pkg::BIT_POLL] == !$past(cur_ff.cpl))
		else $error("final status read did not show true bit seven");

	chk_reset_after_fail: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		cur_ff.st == fsrep_pkg::ST_FAIL && rst_cmd |=> cur_ff.st == ($past(cur_ff.susp_fail)
		? fsrep_pkg::ST_SUSP : fsrep_pkg::ST_READ))
		else $error("reset after failure went to wrong mode");

	chk_burst_wait_low: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		BURST_IN.active && BURST_IN.start |=> !WAIT_N_OUT)
		else $error("wait output not low at initial burst access");

	chk_wait_two_low: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		BURST_IN.active && BURST_IN.start && wait2 ##1 BURST_IN.active |=> !WAIT_N_OUT)
		else $error("wait output not low for second clock");

	chk_erase_timer_high: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		rd_bank && cur_ff.st == fsrep_pkg::ST_ERASE |=> DQ_OUT[fsrep_pkg::BIT_TIMER])
		else $error("timer bit low while erasing");

	chk_erase_cmd_ignored: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		cur_ff.st == fsrep_pkg::ST_ERASE && cmd_is && !CORE_IN.done && !CORE_IN.pulse_limit
		&& (CMD_IN.code != fsrep_pkg::CMD_SUSPEND || cur_ff.chip) |=> cur_ff.st == fsrep_pkg::ST_ERASE)
		else $error("command honoured during erase");

	chk_sprog_toggle: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		rd_bank && cur_ff.st == fsrep_pkg::ST_SPROG |=> DQ_OUT[fsrep_pkg::BIT_TOG1] != $past(cur_ff.tog1))
		else $error("toggle bit one still during suspended program");

endmodule

// ===== rtl/fsrep_pkg.sv
// package of constants and carriers for the flash write status reporter
// assumes one 250 MHz clock shared with the flash core and the register bus
package fsrep_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_MHZ       = 250;
	localparam int unsigned US_PER_MS     = 1000;
	localparam int unsigned PROT_ERASE_US = 100;
	localparam int unsigned PROT_PROG_MS  = 1;
	localparam int unsigned ERASE_TMO_US  = 50;
	localparam int unsigned PROT_ERASE_CYC = PROT_ERASE_US * CLK_MHZ;
	localparam int unsigned PROT_PROG_CYC  = PROT_PROG_MS * US_PER_MS * CLK_MHZ;
	localparam int unsigned ERASE_TMO_CYC  = ERASE_TMO_US * CLK_MHZ;
	localparam int unsigned CNT_W          = 20;
	localparam logic [1:0]  WAIT_ONE_CYC   = 2'h1;
	localparam logic [1:0]  WAIT_TWO_CYC   = 2'h2;
	localparam logic [5:0]  BURST_BOUND    = 6'h3F;

	// ----------------------------------------
	// status byte layout and commands
	// ----------------------------------------
	localparam int unsigned BIT_POLL  = 7;
	localparam int unsigned BIT_TOG1  = 6;
	localparam int unsigned BIT_TMO   = 5;
	localparam int unsigned BIT_TIMER = 3;
	localparam int unsigned BIT_TOG2  = 2;
	localparam logic [7:0]  RESET_DATA = 8'hF0;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam int unsigned AXI_AW       = 8;
	localparam logic [7:0]  OFF_CTRL     = 8'h00;
	localparam logic [7:0]  OFF_STAT     = 8'h04;
	localparam int unsigned CTRL_WAIT2   = 0;
	localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	typedef enum logic [2:0] {
		CMD_NONE, CMD_PROG, CMD_SECT_ERASE, CMD_CHIP_ERASE,
		CMD_SUSPEND, CMD_RESUME, CMD_RESET
	} fsrep_cmd_t;

	typedef enum logic [3:0] {
		ST_READ, ST_PROG, ST_ETMO, ST_ERASE, ST_PROT,
		ST_SUSP, ST_SPROG, ST_FAIL, ST_LAST
	} fsrep_state_t;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic       valid;
		fsrep_cmd_t code;
		logic [7:0] data;
		logic       prot;
		logic       bit7;
	} fsrep_cmd_in_t;

	typedef struct packed {
		logic done;
		logic pulse_limit;
		logic over_zero;
	} fsrep_core_t;

	typedef struct packed {
		logic       valid;
		logic       in_bank;
		logic       sel;
		logic [7:0] array;
	} fsrep_read_t;

	typedef struct packed {
		logic       active;
		logic       start;
		logic       word;
		logic [5:0] addr;
	} fsrep_burst_t;

	typedef struct packed {
		logic              awvalid;
		logic [AXI_AW-1:0] awaddr;
		logic              wvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [AXI_AW-1:0] araddr;
		logic              rready;
	} fsrep_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} fsrep_axi_rsp_t;

endpackage

// ===== rtl/fsrep_regs.sv
// axi4-lite register slave of the status reporter: control and status words
// assumes a master that keeps one write and one read outstanding at most
module fsrep_regs (
	input  wire logic                     clk_in,
	input  wire logic                     resetn_in,
	input  wire fsrep_pkg::fsrep_axi_req_t req_in,
	input  wire logic [31:0]              stat_in,
	output logic                          wait2_out,
	output fsrep_pkg::fsrep_axi_rsp_t     rsp_out
);

	typedef struct packed {
		logic                          aw_held;
		logic [fsrep_pkg::AXI_AW-1:0]  aw_addr;
		logic                          w_held;
		logic [31:0]                   w_data;
		logic [3:0]                    w_strb;
		logic [31:0]                   ctrl;
		fsrep_pkg::fsrep_axi_rsp_t     rsp;
	} fsrep_regs_t;

	fsrep_regs_t cur_ff;
	fsrep_regs_t nxt_regs;

	// ----------------------------------------
	// write and read channels
	// ----------------------------------------
	always_comb begin
		nxt_regs = cur_ff;
		if (req_in.awvalid && cur_ff.rsp.awready) begin
			nxt_regs.aw_held = 1'b1;
			nxt_regs.aw_addr = req_in.awaddr;
		end
		if (req_in.wvalid && cur_ff.rsp.wready) begin
			nxt_regs.w_held = 1'b1;
			nxt_regs.w_data = req_in.wdata;
			nxt_regs.w_strb = req_in.wstrb;
		end
		if (cur_ff.rsp.bvalid && req_in.bready) begin
			nxt_regs.rsp.bvalid = 1'b0;
		end
		if (cur_ff.aw_held && cur_ff.w_held && !cur_ff.rsp.bvalid) begin
			nxt_regs.aw_held    = 1'b0;
			nxt_regs.w_held     = 1'b0;
			nxt_regs.rsp.bvalid = 1'b1;
			nxt_regs.rsp.bresp  = fsrep_pkg::RESP_SLVERR;
			if (cur_ff.aw_addr == fsrep_pkg::OFF_CTRL) begin
				nxt_regs.rsp.bresp = fsrep_pkg::RESP_OKAY;
				if (cur_ff.w_strb[0]) begin
					nxt_regs.ctrl[7:0] = cur_ff.w_data[7:0];
				end
			end else if (cur_ff.aw_addr == fsrep_pkg::OFF_STAT) begin
				nxt_regs.rsp.bresp = fsrep_pkg::RESP_OKAY;
			end
		end
		nxt_regs.rsp.awready = !nxt_regs.aw_held && !nxt_regs.rsp.bvalid;
		nxt_regs.rsp.wready  = !nxt_regs.w_held && !nxt_regs.rsp.bvalid;
		if (cur_ff.rsp.rvalid && req_in.rready) begin
			nxt_regs.rsp.rvalid = 1'b0;
		end
		if (req_in.arvalid && cur_ff.rsp.arready) begin
			nxt_regs.rsp.rvalid = 1'b1;
			nxt_regs.rsp.rresp  = fsrep_pkg::RESP_OKAY;
			case (req_in.araddr)
				fsrep_pkg::OFF_CTRL: nxt_regs.rsp.rdata = cur_ff.ctrl;
				fsrep_pkg::OFF_STAT: nxt_regs.rsp.rdata = stat_in;
				default: begin
					nxt_regs.rsp.rdata = 32'h0000_0000;
					nxt_regs.rsp.rresp = fsrep_pkg::RESP_SLVERR;
				end
			endcase
		end
		nxt_regs.rsp.arready = !nxt_regs.rsp.rvalid;
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cur_ff         <= '0;
			cur_ff.ctrl    <= fsrep_pkg::CTRL_RST;
		end else begin
			cur_ff <= nxt_regs;
		end
	end

	assign rsp_out   = cur_ff.rsp;
	assign wait2_out = cur_ff.ctrl[fsrep_pkg::CTRL_WAIT2];

	chk_unmapped_read: assert property (@(posedge clk_in) disable iff (!resetn_in)
		req_in.arvalid && cur_ff.rsp.arready && req_in.araddr != fsrep_pkg::OFF_CTRL
		&& req_in.araddr != fsrep_pkg::OFF_STAT |=> rsp_out.rvalid && rsp_out.rresp == fsrep_pkg::RESP_SLVERR)
		else $error("unmapped read not answered with slverr");

endmodule

// ===== testbench/fsrep_host_model.sv
// host memory controller model: completes status reads of the bank
// assumes tb_top drives commands and core events itself
module fsrep_host_model (
	input  wire logic               clk_in,
	input  wire logic [7:0]         dq_in,
	output fsrep_pkg::fsrep_read_t  read_out
);
	timeunit 1ns;
	timeprecision 1ps;

	initial read_out = '0;

	// ----------------------------------------
	// one read cycle, bus released afterwards
	// ----------------------------------------
	task automatic rd(input logic bank, input logic sel, input logic [7:0] arr, output logic [7:0] dq);
		@(posedge clk_in);
		read_out <= '{valid: 1'b1, in_bank: bank, sel: sel, array: arr};
		@(posedge clk_in);
		read_out.valid <= 1'b0;
		read_out.array <= ~arr;
		@(negedge clk_in);
		dq = dq_in;
	endtask
endmodule

// ===== testbench/tb_top.sv
// self-checking bench of the flash write status reporter
// assumes short protected and erase time-out counts of 20 cycles
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned N = 20;
	logic clk;
	logic rstn;
	fsrep_pkg::fsrep_cmd_in_t  cmd;
	fsrep_pkg::fsrep_core_t    core;
	fsrep_pkg::fsrep_read_t    rdq;
	fsrep_pkg::fsrep_burst_t   bst;
	fsrep_pkg::fsrep_axi_req_t req;
	fsrep_pkg::fsrep_axi_rsp_t rsp;
	logic [7:0] dq;
	logic       wait_n;
	logic       busy;
	int         n_fail;
	int         n_tests;
	logic [7:0] a;
	logic [7:0] b;
	logic [31:0] d;
	logic [1:0] r;

	fsrep_top #(.PROT_ERASE_CYC(N), .PROT_PROG_CYC(N), .ERASE_TMO_CYC(N)) dut (.CLK_IN(clk), .RESETN_IN(rstn),
		.CMD_IN(cmd), .CORE_IN(core), .READ_IN(rdq), .BURST_IN(bst), .AXI_REQ_IN(req),
		.AXI_RSP_OUT(rsp), .DQ_OUT(dq), .WAIT_N_OUT(wait_n), .BUSY_OUT(busy));
	fsrep_host_model host (.clk_in(clk), .dq_in(dq), .read_out(rdq));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("compares %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic go(input fsrep_pkg::fsrep_cmd_t c, input logic p, input logic b7, input logic [7:0] dt);
		@(posedge clk);
		cmd <= '{valid: 1'b1, code: c, data: dt, prot: p, bit7: b7};
		@(posedge clk);
		cmd.valid <= 1'b0;
		@(negedge clk);
	endtask

	task automatic ev(input logic dn, input logic pl, input logic oz);
		@(posedge clk);
		core <= '{done: dn, pulse_limit: pl, over_zero: oz};
		@(posedge clk);
		core <= '0;
	endtask

	task automatic axw(input logic [7:0] ad, input logic [31:0] wd, output logic [1:0] rs);
		@(posedge clk);
		req.awvalid <= 1'b1;
		req.awaddr <= ad;
		req.wvalid <= 1'b1;
		req.wdata <= wd;
		req.wstrb <= 4'hF;
		req.bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
			if (rsp.bvalid) begin
				rs = rsp.bresp;
				req.bready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic axr(input logic [7:0] ad, output logic [31:0] rd, output logic [1:0] rs);
		@(posedge clk);
		req.arvalid <= 1'b1;
		req.araddr <= ad;
		req.rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
			if (rsp.rvalid) begin
				rd = rsp.rdata;
				rs = rsp.rresp;
				req.rready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic bu(input logic act, input logic st, input logic wd, input logic [5:0] ad, input logic [2:0] lows);
		@(posedge clk);
		bst <= '{active: act, start: st, word: wd, addr: ad};
		@(posedge clk);
		bst.start <= 1'b0;
		bst.word <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			@(negedge clk);
			chk(wait_n, lows[i] ? 1'b0 : 1'b1);
		end
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs_burst();
		chk({dq, wait_n, busy}, 10'h002);
		axw(fsrep_pkg::OFF_CTRL, 32'h0000_0001, r);
		chk(r, fsrep_pkg::RESP_OKAY);
		axr(fsrep_pkg::OFF_CTRL, d, r);
		chk(d, 32'h0000_0001);
		axr(8'h08, d, r);
		chk(r, fsrep_pkg::RESP_SLVERR);
		chk(d, 32'h0000_0000);
		axw(8'h0C, 32'h0000_0001, r);
		chk(r, fsrep_pkg::RESP_SLVERR);
		bu(1'b1, 1'b1, 1'b0, 6'h00, 3'b011);
		axw(fsrep_pkg::OFF_CTRL, 32'h0, r);
		bu(1'b1, 1'b1, 1'b0, 6'h00, 3'b001);
		bu(1'b1, 1'b0, 1'b1, 6'h3F, 3'b001);
		bu(1'b1, 1'b0, 1'b1, 6'h3E, 3'b000);
		bu(1'b0, 1'b1, 1'b0, 6'h00, 3'b000);
		@(posedge clk);
		bst <= '0;
	endtask

	task automatic t_prog();
		go(fsrep_pkg::CMD_PROG, 1'b0, 1'b1, 8'hA0);
		chk(busy, 1'b1);
		host.rd(1'b1, 1'b0, 8'h00, a);
		chk({a[7], a[5]}, 2'b00);
		host.rd(1'b1, 1'b0, 8'h00, b);
		chk({a[6] ^ b[6], a[2] ^ b[2]}, 2'b10);
		host.rd(1'b0, 1'b0, 8'h5A, b);
		chk(b, 8'h5A);
		ev(1'b1, 1'b0, 1'b0);
		host.rd(1'b1, 1'b0, 8'hC3, b);
		chk(b[7], 1'b1);
		host.rd(1'b1, 1'b0, 8'hC3, b);
		chk({b, busy}, {8'hC3, 1'b0});
	endtask

	task automatic t_erase();
		go(fsrep_pkg::CMD_SECT_ERASE, 1'b0, 1'b0, 8'h30);
		host.rd(1'b1, 1'b1, 8'h00, a);
		chk({a[7], a[3]}, 2'b00);
		go(fsrep_pkg::CMD_SECT_ERASE, 1'b0, 1'b0, 8'h30);
		repeat (13) @(posedge clk);
		host.rd(1'b1, 1'b1, 8'h00, a);
		chk(a[3], 1'b0);
		repeat (5) @(posedge clk);
		host.rd(1'b1, 1'b1, 8'h00, b);
		chk({b[3], a[2] ^ b[2], a[6] ^ b[6]}, 3'b111);
		host.rd(1'b1, 1'b0, 8'h00, a);
		host.rd(1'b1, 1'b0, 8'h00, b);
		chk({a[6] ^ b[6], a[2] ^ b[2]}, 2'b10);
		go(fsrep_pkg::CMD_SUSPEND, 1'b0, 1'b0, 8'hB0);
		host.rd(1'b1, 1'b1, 8'h00, a);
		host.rd(1'b1, 1'b1, 8'h00, b);
		chk({b[7], a[6] ^ b[6], a[2] ^ b[2]}, 3'b101);
		host.rd(1'b1, 1'b0, 8'h3C, b);
		chk(b, 8'h3C);
		go(fsrep_pkg::CMD_RESUME, 1'b0, 1'b0, 8'h30);
		ev(1'b1, 1'b0, 1'b0);
		host.rd(1'b1, 1'b1, 8'h00, a);
		host.rd(1'b1, 1'b1, 8'h77, b);
		chk({b, busy}, {8'h77, 1'b0});
	endtask

	task automatic t_fail(input logic oz);
		go(fsrep_pkg::CMD_PROG, 1'b0, 1'b0, 8'hA0);
		if (oz) ev(1'b0, 1'b0, 1'b1);
		if (oz) ev(1'b1, 1'b0, 1'b0);
		chk(busy, 1'b1);
		ev(1'b0, 1'b1, 1'b0);
		host.rd(1'b1, 1'b0, 8'h00, a);
		host.rd(1'b1, 1'b0, 8'h00, b);
		chk({a[5], b[5], a[6] ^ b[6]}, 3'b111);
		go(fsrep_pkg::CMD_RESET, 1'b0, 1'b0, fsrep_pkg::RESET_DATA);
		host.rd(1'b1, 1'b0, 8'h96, b);
		chk({b, busy}, {8'h96, 1'b0});
	endtask

	task automatic t_susp_prog();
		go(fsrep_pkg::CMD_SECT_ERASE, 1'b0, 1'b0, 8'h30);
		go(fsrep_pkg::CMD_SUSPEND, 1'b0, 1'b0, 8'hB0);
		go(fsrep_pkg::CMD_PROG, 1'b0, 1'b1, 8'hA0);
		host.rd(1'b1, 1'b0, 8'h00, a);
		host.rd(1'b1, 1'b0, 8'h00, b);
		chk({b[7], a[6] ^ b[6], a[2] ^ b[2]}, 3'b010);
		ev(1'b0, 1'b1, 1'b0);
		axr(fsrep_pkg::OFF_STAT, d, r);
		chk(d, 32'h0000_00B7);
		go(fsrep_pkg::CMD_RESET, 1'b0, 1'b0, fsrep_pkg::RESET_DATA);
		host.rd(1'b1, 1'b1, 8'h00, b);
		chk({b[7], b[5], busy}, 3'b101);
		go(fsrep_pkg::CMD_RESUME, 1'b0, 1'b0, 8'h30);
		go(fsrep_pkg::CMD_SECT_ERASE, 1'b0, 1'b0, 8'h30);
		axr(fsrep_pkg::OFF_STAT, d, r);
		chk({d[7], d[3:0]}, {1'b1, fsrep_pkg::ST_ERASE});
		ev(1'b1, 1'b0, 1'b0);
		host.rd(1'b1, 1'b1, 8'h00, a);
		host.rd(1'b1, 1'b1, 8'h55, b);
		chk({b, busy}, {8'h55, 1'b0});
	endtask

	task automatic t_chip();
		go(fsrep_pkg::CMD_CHIP_ERASE, 1'b0, 1'b0, 8'h10);
		host.rd(1'b1, 1'b1, 8'h00, a);
		go(fsrep_pkg::CMD_SUSPEND, 1'b0, 1'b0, 8'hB0);
		host.rd(1'b1, 1'b1, 8'h00, b);
		chk({a[3], a[7], a[6] ^ b[6], b[7]}, 4'b1010);
		ev(1'b1, 1'b0, 1'b0);
		host.rd(1'b1, 1'b1, 8'h00, a);
		host.rd(1'b1, 1'b1, 8'hE1, b);
		chk({a[7], b, busy}, {1'b1, 8'hE1, 1'b0});
	endtask

	task automatic t_prot(input fsrep_pkg::fsrep_cmd_t c);
		go(c, 1'b1, 1'b0, 8'h30);
		host.rd(1'b1, 1'b1, 8'h00, a);
		host.rd(1'b1, 1'b1, 8'h00, b);
		chk({busy, a[6] ^ b[6]}, 2'b11);
		if (c == fsrep_pkg::CMD_SECT_ERASE) chk(b[7], 1'b0);
		repeat (16) @(posedge clk);
		host.rd(1'b1, 1'b1, 8'h69, b);
		chk({b, busy}, {8'h69, 1'b0});
	endtask

	// ----------------------------------------
	// clock, reset, run
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		n_fail = 0;
		n_tests = 0;
		rstn = 1'b0;
		cmd = '0;
		core = '0;
		bst = '0;
		req = '0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		t_regs_burst();
		t_prog();
		t_erase();
		t_susp_prog();
		t_chip();
		t_fail(1'b0);
		t_fail(1'b1);
		t_prot(fsrep_pkg::CMD_SECT_ERASE);
		t_prot(fsrep_pkg::CMD_PROG);
		close_out();
	end

	initial begin
		#40000;
		n_fail++;
		close_out();
	end
endmodule
